// [logic/spioc_flags.sv]
// Purpose: Bank of sticky event flags
// Assumes: Set, clear and flush are on the module clock
// Notes: A set in the same cycle as a clear wins
`timescale 1ns/10ps
module spioc_flags #(
    parameter int W = 4
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    output logic [W-1:0] flag_o
);
    // Flush empties all, then clears, set applied last
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            flag_o <= '0;
        else if (flush_i)
            flag_o <= set_i;
        else
            flag_o <= (flag_o & ~clr_i) | set_i;
    end
endmodule

// [logic/spioc_pkg.sv]
// Purpose: Shared constants and types of the SPI option control block
// Assumes: Byte-wide register port, offsets are byte addresses
// Notes: Flag bit order is shared by status, clear and enable registers
package spioc_pkg;
    // Register offsets
    localparam logic [7:0] OFS_C2 = 8'h02;
    localparam logic [7:0] OFS_CTRL = 8'h03;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_DLO = 8'h05;
    localparam logic [7:0] OFS_DHI = 8'h06;
    localparam logic [7:0] OFS_MLO = 8'h07;
    localparam logic [7:0] OFS_MHI = 8'h08;
    localparam logic [7:0] OFS_CLR = 8'h09;
    localparam logic [7:0] OFS_IEN = 8'h0a;
    // Option control register fields
    localparam int B_MIE = 7;
    localparam int B_WID = 6;
    localparam int B_TXD = 5;
    localparam int B_FEN = 4;
    localparam int B_BOE = 3;
    localparam int B_RXD = 2;
    localparam int B_SWAI = 1;
    localparam int B_SPC = 0;
    // Main control register fields
    localparam int B_ON = 6;
    localparam int B_MST = 4;
    localparam int B_SOE = 1;
    // Flag positions in status, clear and enable
    localparam int S_RXF = 0;
    localparam int S_TXE = 1;
    localparam int S_MAT = 2;
    localparam int S_FLT = 3;
    localparam int NFLAG = 4;
    // Reset values
    localparam logic [7:0] C2_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] IEN_RST = 4'h0;
    localparam logic [3:0] FLAG_RST = 4'h0;
    // Synchroniser idle levels: select high, clock and data low
    localparam logic [3:0] SYNC_RST = 4'h8;
    // Timing: module clock and master serial clock periods
    localparam int CLK_NS = 4;
    localparam int SCLK_NS = 32;
    localparam int HALF_CYC = SCLK_NS / (2 * CLK_NS);
    // Transfer engine states
    typedef enum logic [0:0] {
        SPIOC_IDLE = 1'b0,
        SPIOC_RUN = 1'b1
    } spioc_state_t;
endpackage

// [logic/spioc_sync.sv]
// Purpose: Two-flop synchroniser for pins from outside the clock domain
// Assumes: Each bit is an independent level
// Notes: Reset level per bit is a parameter
`timescale 1ns/10ps
module spioc_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q; // First stage, read only by second stage

    // Two stages, only the second looks at the first
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            meta_q <= RST_VAL;
            q_o <= RST_VAL;
        end
        else
        begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// [logic/spioc_top.sv]
// Purpose: SPI engine with option control register and pin steering
// Assumes: Mode 0 timing, MSB first; link clock sampled by mclk_i
// Notes: Status, clear and enable registers share one flag layout
// Overview of operation
// RQ1: Byte option register at offset two, reset zero
// RQ2: Match flag interrupts only with match enable
// RQ3: Width bit picks eight or sixteen bit words
// RQ4: Master width change aborts, idles, clears status
// RQ5: Transmit DMA request on empty and module on
// RQ6: Transmit DMA enable masks transmit empty interrupt
// RQ7: Slave ignores fault enable; select is input
// RQ8: Master without fault enable releases select pin
// RQ9: Master with fault enable: fault in or select out
// RQ10: Single pin drive enable gates data driver
// RQ11: Drive enable clear makes single pin input
// RQ12: Drive enable ignored outside single pin mode
// RQ13: Receive DMA request on full; masks full interrupt
// RQ14: Single pin mode selects one shared data wire
`timescale 1ns/10ps
module spioc_top
    import spioc_pkg::*;
#(
    parameter int HALF_DIV = HALF_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic irq_o,
    output logic tx_dma_req_o,
    output logic rx_dma_req_o,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_n_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_n_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    input wire logic ss_i,
    output logic ss_o,
    output logic ss_oe_n_o
);
    logic [7:0] c2_q; // Option control
    logic [7:0] ctrl_q; // Module on, master, select output
    logic [3:0] ien_q; // Interrupt enables
    logic [7:0] tx_hi_q; // Staged upper transmit byte
    logic [15:0] tx_buf_q; // Transmit buffer
    logic tx_full_q; // Transmit buffer holds a word
    logic [15:0] rx_q; // Receive buffer
    logic [15:0] match_q; // Match value
    logic [7:0] rdata_q; // Read answer
    spioc_state_t state_q; // Master engine state
    logic [7:0] div_q; // Half period counter
    logic sclk_q; // Master serial clock
    logic [3:0] bit_q; // Bits done in current word
    logic samp_q; // Bit caught on rising edge
    logic [15:0] sh_q; // Shift register
    logic sck_p_q; // Previous synced link clock
    logic ss_p_q; // Previous synced select
    logic [3:0] fl; // Sticky flags
    logic [3:0] fl_set;
    logic [3:0] fl_clr;
    logic ss_s, sck_s, mosi_s, miso_s; // Synced pins
    logic wr_c2, wr_ctrl, wr_dlo, wr_dhi, wr_mlo, wr_mhi;
    logic wr_clr, wr_ien, rd_dlo;
    logic mie, w16, txd, fen, boe, rxd, spc, on, mst, soe;
    logic abort, flush, fault_hit, m_tick, m_rise, m_fall;
    logic s_act, s_rise, s_fall, s_sel, rise, fall, done;
    logic m_start, take, in_bit, out_bit;
    logic [3:0] last;
    logic [15:0] word, rxw, mmask;
    logic [3:0] gate;

    // Field aliases
    assign mie = c2_q[B_MIE];
    assign w16 = c2_q[B_WID];
    assign txd = c2_q[B_TXD];
    assign fen = c2_q[B_FEN];
    assign boe = c2_q[B_BOE];
    assign rxd = c2_q[B_RXD];
    assign spc = c2_q[B_SPC];
    assign on = ctrl_q[B_ON];
    assign mst = ctrl_q[B_MST];
    assign soe = ctrl_q[B_SOE];

    // Pins from the link pass two flops first
    spioc_sync #(
        .W(4),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .d_i({ss_i, sclk_i, mosi_i, miso_i}),
        .q_o({ss_s, sck_s, mosi_s, miso_s})
    );

    // Write and read strobe decode
    always_comb
    begin
        wr_c2 = 1'b0;
        wr_ctrl = 1'b0;
        wr_dlo = 1'b0;
        wr_dhi = 1'b0;
        wr_mlo = 1'b0;
        wr_mhi = 1'b0;
        wr_clr = 1'b0;
        wr_ien = 1'b0;
        rd_dlo = rd_i && (addr_i == OFS_DLO);
        if (wr_i)
        begin
            if (addr_i == OFS_C2)
                wr_c2 = 1'b1;
            else if (addr_i == OFS_CTRL)
                wr_ctrl = 1'b1;
            else if (addr_i == OFS_DLO)
                wr_dlo = 1'b1;
            else if (addr_i == OFS_DHI)
                wr_dhi = 1'b1;
            else if (addr_i == OFS_MLO)
                wr_mlo = 1'b1;
            else if (addr_i == OFS_MHI)
                wr_mhi = 1'b1;
            else if (addr_i == OFS_CLR)
                wr_clr = 1'b1;
            else if (addr_i == OFS_IEN)
                wr_ien = 1'b1;
        end
    end

    // Option control register, all bits zero at reset
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            c2_q <= C2_RST; // [RQ1]
        else if (wr_c2)
            c2_q <= wdata_i; // [RQ1]
    end

    // Main control and interrupt enable registers
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= CTRL_RST;
            ien_q <= IEN_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= wdata_i;
            if (wr_ien)
                ien_q <= wdata_i[3:0];
        end
    end

    // Match value and staged upper transmit byte
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            match_q <= 16'h0000;
            tx_hi_q <= 8'h00;
        end
        else
        begin
            if (wr_mlo)
                match_q[7:0] <= wdata_i;
            if (wr_mhi)
                match_q[15:8] <= wdata_i;
            if (wr_dhi)
                tx_hi_q <= wdata_i;
        end
    end

    // Abort and fault conditions
    // Width change in master mode aborts at once
    assign abort = wr_c2 && mst && (wdata_i[B_WID] != w16); // [RQ4]
    assign flush = abort || !on; // [RQ4]
    // Fault only in master mode, fault enabled, select as input
    assign fault_hit = on && mst && fen && !soe && !ss_s; // [RQ7] [RQ8] [RQ9]

    // Word length and edge events
    assign last = w16 ? 4'd15 : 4'd7; // [RQ3]
    assign m_tick = (state_q == SPIOC_RUN) && (div_q == 8'(HALF_DIV - 1));
    assign m_rise = m_tick && !sclk_q;
    assign m_fall = m_tick && sclk_q;
    assign s_act = on && !mst && !ss_s; // [RQ7]
    assign s_rise = s_act && sck_s && !sck_p_q;
    assign s_fall = s_act && !sck_s && sck_p_q;
    assign s_sel = s_act && ss_p_q;
    assign rise = mst ? m_rise : s_rise;
    assign fall = mst ? m_fall : s_fall;
    assign done = fall && (bit_q == last);
    assign word = {sh_q[14:0], samp_q};
    assign rxw = w16 ? word : {8'h00, word[7:0]}; // [RQ3]
    assign mmask = w16 ? match_q : {8'h00, match_q[7:0]}; // [RQ3]
    assign m_start = on && mst && (state_q == SPIOC_IDLE) && tx_full_q
        && !abort && !fault_hit;
    assign take = m_start || ((done || s_sel) && tx_full_q);

    // Master engine state
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || abort || fault_hit || !on || !mst)
            state_q <= SPIOC_IDLE; // [RQ4]
        else
        begin
            case (state_q)
                SPIOC_IDLE:
                    if (m_start)
                        state_q <= SPIOC_RUN;
                SPIOC_RUN:
                    if (done && !tx_full_q)
                        state_q <= SPIOC_IDLE;
                default:
                    state_q <= SPIOC_IDLE;
            endcase
        end
    end

    // Half period divider and master clock
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || abort || (state_q != SPIOC_RUN))
        begin
            div_q <= 8'h00;
            sclk_q <= 1'b0; // [RQ4]
        end
        else if (m_tick)
        begin
            div_q <= 8'h00;
            sclk_q <= !sclk_q;
        end
        else
            div_q <= div_q + 8'h01;
    end

    // Bit counter; slave restarts while deselected
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || abort || take || (!mst && ss_s))
            bit_q <= 4'h0;
        else if (fall)
            bit_q <= done ? 4'h0 : bit_q + 4'h1; // [RQ3]
    end

    // Sample on rising edge, shift on falling edge
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            samp_q <= 1'b0;
            sh_q <= 16'h0000;
        end
        else
        begin
            if (rise)
                samp_q <= in_bit;
            if (take)
                sh_q <= tx_buf_q;
            else if (fall)
                sh_q <= {sh_q[14:0], samp_q};
        end
    end

    // Link edge history
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            sck_p_q <= 1'b0;
            ss_p_q <= 1'b1;
        end
        else
        begin
            sck_p_q <= sck_s;
            ss_p_q <= ss_s;
        end
    end

    // Transmit buffer; a write in a take cycle keeps it full
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || flush)
            tx_full_q <= 1'b0;
        else if (wr_dlo)
            tx_full_q <= 1'b1;
        else if (take)
            tx_full_q <= 1'b0;
    end

    // Upper byte only counts in sixteen bit mode
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            tx_buf_q <= 16'h0000;
        else if (wr_dlo)
            tx_buf_q <= {w16 ? tx_hi_q : 8'h00, wdata_i}; // [RQ3]
    end

    // Receive buffer
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            rx_q <= 16'h0000;
        else if (done && !flush)
            rx_q <= rxw;
    end

    // Flag events; abort and module off hold them clear
    always_comb
    begin
        fl_set = 4'h0;
        fl_set[S_RXF] = done;
        fl_set[S_TXE] = on && !tx_full_q && !wr_dlo;
        fl_set[S_MAT] = done && (rxw == mmask);
        fl_set[S_FLT] = fault_hit;
        if (flush)
            fl_set = 4'h0; // [RQ4]
        fl_clr = wr_clr ? wdata_i[3:0] : 4'h0;
        fl_clr[S_RXF] = fl_clr[S_RXF] || rd_dlo;
        fl_clr[S_TXE] = fl_clr[S_TXE] || wr_dlo;
    end

    spioc_flags #(
        .W(NFLAG)
    ) u_flags (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .flush_i(flush),
        .set_i(fl_set),
        .clr_i(fl_clr),
        .flag_o(fl)
    );

    // Interrupt gating per flag source
    always_comb
    begin
        gate = 4'hf;
        gate[S_MAT] = mie; // [RQ2]
        gate[S_TXE] = !txd; // [RQ6]
        gate[S_RXF] = !rxd; // [RQ13]
    end
    assign irq_o = |(fl & ien_q & gate); // [RQ2] [RQ6] [RQ13]

    // DMA requests
    assign tx_dma_req_o = txd && fl[S_TXE] && on; // [RQ5]
    assign rx_dma_req_o = rxd && fl[S_RXF] && on; // [RQ13]

    // Data pin steering
    assign out_bit = w16 ? sh_q[15] : sh_q[7]; // [RQ3]
    // Master reads the shared pin in single pin mode
    assign in_bit = mst ? (spc ? mosi_s : miso_s)
        : (spc ? miso_s : mosi_s); // [RQ14]
    assign mosi_o = out_bit;
    assign miso_o = out_bit;
    // Drive enable only matters with single pin mode
    assign mosi_oe_n_o = !(on && mst && (!spc || boe)); // [RQ10] [RQ11] [RQ12]
    assign miso_oe_n_o = !(s_act && (!spc || boe)); // [RQ10] [RQ11] [RQ12]
    assign sclk_o = sclk_q;
    assign sclk_oe_n_o = !(on && mst);

    // Select pin: output only for master with fault enable
    assign ss_oe_n_o = !(on && mst && fen && soe); // [RQ8] [RQ9]
    assign ss_o = (state_q != SPIOC_RUN); // [RQ9]

    // Read answer, one cycle after the strobe
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || !rd_i)
            rdata_q <= 8'h00;
        else if (addr_i == OFS_C2)
            rdata_q <= c2_q; // [RQ1]
        else if (addr_i == OFS_CTRL)
            rdata_q <= ctrl_q;
        else if (addr_i == OFS_STAT)
            rdata_q <= {4'h0, fl};
        else if (addr_i == OFS_DLO)
            rdata_q <= rx_q[7:0];
        else if (addr_i == OFS_DHI)
            rdata_q <= rx_q[15:8];
        else if (addr_i == OFS_MLO)
            rdata_q <= match_q[7:0];
        else if (addr_i == OFS_MHI)
            rdata_q <= match_q[15:8];
        else if (addr_i == OFS_IEN)
            rdata_q <= {4'h0, ien_q};
        else
            rdata_q <= 8'h00;
    end
    assign rdata_o = rdata_q;

    // Checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_flip;
        mst && wr_c2 && (wdata_i[B_WID] != w16) && (state_q == SPIOC_RUN);
    endsequence
    sequence s_word8;
        done && !w16 && !flush;
    endsequence

    c2_reset_a: assert property (disable iff (1'b0) // [RQ1]
        rst_i |=> c2_q == C2_RST) else $error("option reg not cleared");
    match_irq_a: assert property ( // [RQ2]
        (fl == 4'h4) && ien_q[S_MAT] |-> irq_o == mie)
        else $error("match irq gating wrong");
    word_len_a: assert property ( // [RQ3]
        s_word8 |-> bit_q == 4'd7 ##1 rx_q[15:8] == 8'h00)
        else $error("eight bit word length wrong");
    width_abort_a: assert property ( // [RQ4]
        s_flip |=> (state_q == SPIOC_IDLE) && (fl == 4'h0) && !sclk_q)
        else $error("width change did not abort");
    tx_dma_a: assert property ( // [RQ5]
        txd && on && !tx_full_q && !wr_dlo && !abort ##1 txd && on
        |-> tx_dma_req_o) else $error("tx dma request missing");
    tx_mask_a: assert property ( // [RQ6]
        (fl == 4'h2) && txd |-> !irq_o)
        else $error("tx empty irq not masked");
    slave_sel_a: assert property ( // [RQ7]
        !mst |-> ss_oe_n_o && !fault_hit)
        else $error("slave drove select or faulted");
    ss_release_a: assert property ( // [RQ8]
        mst && !fen |-> ss_oe_n_o && !fault_hit)
        else $error("select pin not released");
    ss_out_a: assert property ( // [RQ9]
        on && mst && fen && soe && (state_q == SPIOC_RUN)
        |-> !ss_oe_n_o && !ss_o) else $error("select output not low");
    bidir_in_a: assert property ( // [RQ11]
        on && mst && spc && !boe |-> mosi_oe_n_o && miso_oe_n_o)
        else $error("single pin not input");
    bidir_out_a: assert property ( // [RQ10]
        on && mst && spc && boe |-> !mosi_oe_n_o && miso_oe_n_o)
        else $error("single pin not driven");
    normal_pin_a: assert property ( // [RQ12]
        on && mst && !spc |-> !mosi_oe_n_o)
        else $error("drive enable affected normal pins");
    rx_dma_a: assert property ( // [RQ13]
        rxd && on && fl[S_RXF] |-> rx_dma_req_o && !(irq_o && fl == 4'h1))
        else $error("rx dma handling wrong");
endmodule

// [sim/spi_option_control_test.sv]
// Purpose: Self-checking bench for the SPI option control block
// Assumes: Register port with read data one cycle after the strobe
// Notes: Pin levels are resolved here from the output enables
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    num_errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module spi_option_control_test;
    import spioc_pkg::*;
    logic mclk, rst, wr, rd, wide;
    logic [7:0] addr, wdata, rdata, rdata_w;
    logic irq, txreq, rxreq, sclk_o, sclk_oe_n, mosi_o, mosi_oe_n;
    logic miso_o, miso_oe_n, ss_o, ss_oe_n, pmiso;
    logic [15:0] ptx, prx;
    int num_errors = 0;
    int samples_checked = 0;
    // Wire levels: select has a pull-up, a released mosi line inverts, a released miso line follows the partner
    wire sclk_w = sclk_oe_n ? 1'b0 : sclk_o;
    wire mosi_w = mosi_oe_n ? ~mosi_o : mosi_o;
    wire miso_w = miso_oe_n ? pmiso : miso_o;
    wire ss_w = ss_oe_n ? 1'b1 : ss_o;
    spioc_top #(.HALF_DIV(4)) dut (.mclk_i(mclk), .rst_i(rst),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata_w), .irq_o(irq), .tx_dma_req_o(txreq),
        .rx_dma_req_o(rxreq), .sclk_i(sclk_w), .sclk_o(sclk_o),
        .sclk_oe_n_o(sclk_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_o),
        .mosi_oe_n_o(mosi_oe_n), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe_n_o(miso_oe_n), .ss_i(ss_w), .ss_o(ss_o),
        .ss_oe_n_o(ss_oe_n));
    spioc_slave_model partner (.sclk_i(sclk_w), .ss_n_i(ss_w),
        .mosi_i(mosi_w), .wide_i(wide), .tx_word_i(ptx),
        .miso_o(pmiso), .rx_word_o(prx));
    // Free-running module clock
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Let n edges pass, then sample settled outputs
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // One-cycle register write
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    // One-cycle register read, data taken in the following cycle
    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata_w;
    endtask
    // Reset values, read-back and an unmapped place
    task automatic t_regs();
        rreg(OFS_C2, rdata);
        `CHK("c2 reset", 8'h00, rdata)
        wreg(OFS_C2, 8'h2f);
        rreg(OFS_C2, rdata);
        `CHK("c2 readback", 8'h2f, rdata)
        wreg(OFS_C2, 8'h00);
        rreg(8'h0b, rdata);
        `CHK("unmapped", 8'h00, rdata)
        $display("test regs done");
    endtask
    // Transmit empty interrupt versus transmit DMA request
    task automatic t_txirq();
        wreg(OFS_CTRL, 8'h40);
        wreg(OFS_IEN, 8'h02);
        step(2);
        `CHK("tx irq", 1'b1, irq)
        `CHK("tx req off", 1'b0, txreq)
        wreg(OFS_C2, 8'h20);
        step(2);
        `CHK("tx irq masked", 1'b0, irq)
        `CHK("tx req", 1'b1, txreq)
        wreg(OFS_CTRL, 8'h00);
        step(2);
        `CHK("tx req module off", 1'b0, txreq)
        wreg(OFS_C2, 8'h00);
        wreg(OFS_IEN, 8'h00);
        $display("test tx irq done");
    endtask
    // One pin steering case
    task automatic pin_case(input logic [7:0] c, input logic [7:0] o,
                            input logic ess, input logic emo);
        wreg(OFS_CTRL, c);
        wreg(OFS_C2, o);
        step(2);
        `CHK("ss oe_n", ess, ss_oe_n)
        `CHK("mosi oe_n", emo, mosi_oe_n)
        `CHK("miso oe_n", 1'b1, miso_oe_n)
        `CHK("sclk oe_n", ~(c[B_ON] & c[B_MST]), sclk_oe_n)
    endtask
    // Select and data pin steering across modes
    task automatic t_pins();
        pin_case(8'h50, 8'h00, 1'b1, 1'b0);
        pin_case(8'h52, 8'h10, 1'b0, 1'b0);
        pin_case(8'h42, 8'h10, 1'b1, 1'b1);
        pin_case(8'h50, 8'h01, 1'b1, 1'b1);
        pin_case(8'h50, 8'h09, 1'b1, 1'b0);
        pin_case(8'h50, 8'h08, 1'b1, 1'b0);
        wreg(OFS_CTRL, 8'h00);
        wreg(OFS_C2, 8'h00);
        $display("test pins done");
    endtask
    // Master transfer with match, receive DMA and word width
    task automatic t_xfer(input logic w, input logic [15:0] mo,
                          input logic [15:0] so);
        int n;
        wide = w;
        ptx = so;
        wreg(OFS_C2, {1'b1, w, 6'b010100});
        wreg(OFS_MLO, so[7:0]);
        wreg(OFS_MHI, so[15:8]);
        wreg(OFS_IEN, 8'h05);
        wreg(OFS_CTRL, 8'h52);
        wreg(OFS_DHI, mo[15:8]);
        wreg(OFS_DLO, mo[7:0]);
        n = 0;
        do begin
            rreg(OFS_STAT, rdata);
            n++;
        end while (rdata[S_RXF] !== 1'b1 && n < 100);
        `CHK("rx full", 1'b1, rdata[S_RXF])
        `CHK("match flag", 1'b1, rdata[S_MAT])
        `CHK("rx req", 1'b1, rxreq)
        `CHK("match irq", 1'b1, irq)
        wreg(OFS_C2, {1'b0, w, 6'b010100});
        step(1);
        `CHK("irq inhibited", 1'b0, irq)
        rreg(OFS_DHI, rdata);
        `CHK("rx high", w ? so[15:8] : 8'h00, rdata)
        rreg(OFS_DLO, rdata);
        `CHK("rx low", so[7:0], rdata)
        step(1);
        `CHK("rx req drop", 1'b0, rxreq)
        `CHK("slave got", w ? mo : {8'h00, mo[7:0]}, prx)
        wreg(OFS_CLR, 8'h0f);
        wreg(OFS_CTRL, 8'h00);
        $display("test transfer done");
    endtask
    // Width change in mid-word aborts the master
    task automatic t_abort();
        wide = 1'b1;
        wreg(OFS_C2, 8'h50);
        wreg(OFS_CTRL, 8'h52);
        wreg(OFS_DHI, 8'hc3);
        wreg(OFS_DLO, 8'h3c);
        step(10);
        wreg(OFS_DLO, 8'h5a);
        step(150);
        rreg(OFS_STAT, rdata);
        `CHK("word before abort", 1'b1, rdata[S_RXF])
        `CHK("running", 1'b0, ss_w)
        wreg(OFS_C2, 8'h10);
        step(2);
        `CHK("idle select", 1'b1, ss_w)
        `CHK("idle clock", 1'b0, sclk_o)
        rreg(OFS_STAT, rdata);
        `CHK("status flushed", 8'h00, rdata & 8'h0d)
        step(150);
        rreg(OFS_STAT, rdata);
        `CHK("no late word", 8'h00, rdata & 8'h0d)
        wreg(OFS_CTRL, 8'h00);
        $display("test abort done");
    endtask
    // Counts and verdict, the only way out of the run
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Watchdog well beyond the expected run time
    initial
    begin
        #80000;
        num_errors++;
        give_verdict();
    end
    // Main sequence
    initial
    begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wide = 1'b0;
        ptx = 16'h0000;
        step(9);
        `CHK("irq reset", 1'b0, irq)
        @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_txirq();
        t_pins();
        t_xfer(1'b0, 16'h00a6, 16'h005b);
        t_xfer(1'b1, 16'h9e71, 16'h62d4);
        t_abort();
        give_verdict();
    end
endmodule

// [sim/spioc_slave_model.sv]
// Purpose: Behavioural SPI slave standing on the far side of the link
// Assumes: Mode 0, MSB first, select active low
// Notes: Data line shows the inverse of the last bit while not selected
`timescale 1ns/10ps
module spioc_slave_model (
    input wire logic sclk_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    input wire logic wide_i,
    input wire logic [15:0] tx_word_i,
    output logic miso_o,
    output logic [15:0] rx_word_o
);
    // Outgoing shift register, top bit on the wire
    logic [15:0] sh;
    // Load the word when selected; short words sit in the top byte
    always @(negedge ss_n_i)
    begin
        sh = wide_i ? tx_word_i : {tx_word_i[7:0], 8'h00};
        rx_word_o = 16'h0000;
    end
    // Sample on the rising link clock edge
    always @(posedge sclk_i)
    begin
        if (!ss_n_i)
            rx_word_o = {rx_word_o[14:0], mosi_i};
    end
    // Shift on the falling edge
    always @(negedge sclk_i)
    begin
        if (!ss_n_i)
            sh = sh << 1;
    end
    // Released line must not hold a stale but valid-looking bit
    assign miso_o = ss_n_i ? ~sh[15] : sh[15];
endmodule
